// ---- hdl/cfr_front_end.sv ----
// Channel front end: registers, port select, oscillator control, scaling, resampler
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns

// Contract
// [R1] Control bit 2 adds amplitude dither to the oscillator's Cartesian conversion.
// [R2] Control bit 3 clears the phase accumulator before each hop; offset still applies.
// [R3] Control bit 3 clear makes hops phase continuous.
// [R4] Mode 00 latches every clock while qualifier high, zeros while low.
// [R5] Mode 00 keeps the oscillator advancing while inputs are blanked.
// [R6] Mode 01 latches only while qualifier high and halts oscillator otherwise.
// [R7] Mode 10 latches one sample on first clock after qualifier rises.
// [R8] Mode 11 latches one sample on first clock after qualifier falls.
// [R9] Edge modes advance the oscillator once per newly latched sample.
// [R10] In modes 01, 10, 11 later stages keep running every clock; here the resampler steps only on latched samples.
// [R11] Control bit 6 picks port B over A; all port signals switch together.
// [R12] Control bits 7-8 pick one of four sync pins; pins may be shared.
// [R13] L ranges 1-512, M ranges 1-4096; only L/M not above one is legal.
// [R14] Resampler zero-stuffs by L, then second-order integrator-comb, output rate L/M.
// [R15] L and M both one bypass the filter; scaling still applies.
// [R16] Scale is 5 bits, 0-31; each count is one right shift.
// [R17] Two scale fields, chosen by the level indicator pin.
// [R18] Shift is mod(exp+scale,32), or mod(7-exp+scale,32) when inverted.
// [R19] The combined shift is applied once, just before the resampler.
// [R20] The resampler takes one input per master clock, full port rate.
// [R21] M and L are programmed as value minus one in 12 and 9 bit fields.
// [R22] Scale bit 11 inverts the exponent before the shift calculation.
// [R23] Scale bit 10 selects 6 dB or 12 dB per exponent step.
// [R24] Converter holds samples, exponent, level, qualifier stable at latch edges.
// [R25] Each resampler output comes with a one-cycle valid strobe.
module cfr_front_end
  import cfr_pkg::*;
#(
  parameter int ACC_W = 40,
  parameter int OUT_W = 24
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Converter pins
  input  wire cfr_port_t               port_a,
  input  wire cfr_port_t               port_b,
  input  wire logic                    level_indicator,
  input  wire logic [3:0]              sync_pins,
  // Oscillator control outputs
  output logic [PHASE_W-1:0]           osc_phase_q,
  output logic                         osc_amp_dither_q,
  // Resampled stream
  output logic signed [OUT_W-1:0]      resampled_data,
  output logic                         resampled_valid
);

  // Registers
  logic [CTRL_W-1:0]   channel_front_control_q;
  logic [SSEL_W-1:0]   resampler_scale_control_q;
  logic [DECIM_W-1:0]  decim_m1_q;
  logic [INTERP_W-1:0] interp_m1_q;
  logic [FREQ_W-1:0]   freq_shadow_q;
  logic [PHASE_W-1:0]  phase_offset_q;

  // Bus state
  logic                wr_go;
  logic [IDX_W-1:0]    wr_idx;
  logic                wr_hit;
  logic [31:0]         wr_mask;
  logic [IDX_W-1:0]    rd_idx;
  logic [31:0]         rd_word;
  logic                rd_hit;
  logic [31:0]         status_word;

  // Pin synchronisers
  cfr_port_t           port_a_s1_q, port_a_s2_q;
  cfr_port_t           port_b_s1_q, port_b_s2_q;
  logic                level_s1_q, level_s2_q;
  logic [3:0]          sync_s1_q, sync_s2_q;

  // Oscillator state
  logic                sync_sel_prev_q;
  logic                sync_sel;
  logic                hop;
  logic [FREQ_W-1:0]   freq_active_q;
  logic [FREQ_W-1:0]   phase_acc_q;
  logic [15:0]         lfsr_q;

  // Data path
  cfr_port_t           port_sel;
  cfr_qual_mode_t      qual_mode;
  logic [DATA_W-1:0]   q_sample;
  logic [EXP_W-1:0]    q_exponent;
  logic                q_load;
  logic                q_advance;
  logic [SCALE_W-1:0]  scale_pick;
  logic [SCALE_W-1:0]  exp_eff;
  logic [SCALE_W-1:0]  shift_amt;
  logic signed [DATA_W-1:0] scaled_q;
  logic                scaled_load_q;
  logic                rate_legal;

  // Write channel: take address and data together, answer next cycle
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign wr_idx        = s_axi_awaddr[IDX_W+1:2];
  assign wr_hit        = (wr_idx == IDX_FREQ) || (wr_idx == IDX_PHASE)
                      || (wr_idx == IDX_CTRL) || (wr_idx == IDX_DECIM)
                      || (wr_idx == IDX_INTERP) || (wr_idx == IDX_SCALE);

  // Byte lane mask from strobes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{s_axi_wstrb[b]}};
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register storage with byte enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_front_control_q   <= RST_CTRL;
      resampler_scale_control_q <= RST_SCALE;
      decim_m1_q                <= RST_DECIM;
      interp_m1_q               <= RST_INTERP;
      freq_shadow_q             <= RST_FREQ;
      phase_offset_q            <= RST_PHASE;
    end else if (wr_go) begin
      unique case (wr_idx)
        IDX_CTRL:   channel_front_control_q <= CTRL_W'((s_axi_wdata & wr_mask)
                      | ({23'h0, channel_front_control_q} & ~wr_mask));
        IDX_SCALE:  resampler_scale_control_q <= SSEL_W'((s_axi_wdata & wr_mask)
                      | ({20'h0, resampler_scale_control_q} & ~wr_mask));
        IDX_DECIM:  decim_m1_q <= DECIM_W'((s_axi_wdata & wr_mask)
                      | ({20'h0, decim_m1_q} & ~wr_mask));              // [R21]
        IDX_INTERP: interp_m1_q <= INTERP_W'((s_axi_wdata & wr_mask)
                      | ({23'h0, interp_m1_q} & ~wr_mask));             // [R21]
        IDX_FREQ:   freq_shadow_q <= (s_axi_wdata & wr_mask) | (freq_shadow_q & ~wr_mask);
        IDX_PHASE:  phase_offset_q <= PHASE_W'((s_axi_wdata & wr_mask)
                      | ({16'h0, phase_offset_q} & ~wr_mask));
        default: ;
      endcase
    end
  end

  // Status word: rate legality, live qualifier, current phase
  always_comb begin
    status_word = '0;
    status_word[STAT_LEGAL] = rate_legal;
    status_word[STAT_QUAL]  = port_sel.qualifier;
    status_word[STAT_PHASE_LO +: PHASE_W] = osc_phase_q;
  end

  // Read decode
  assign rd_idx = s_axi_araddr[IDX_W+1:2];
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    unique case (rd_idx)
      IDX_FREQ:   rd_word = freq_shadow_q;
      IDX_PHASE:  rd_word[PHASE_W-1:0]  = phase_offset_q;
      IDX_CTRL:   rd_word[CTRL_W-1:0]   = channel_front_control_q;
      IDX_DECIM:  rd_word[DECIM_W-1:0]  = decim_m1_q;
      IDX_INTERP: rd_word[INTERP_W-1:0] = interp_m1_q;
      IDX_SCALE:  rd_word[SSEL_W-1:0]   = resampler_scale_control_q;
      IDX_STATUS: rd_word = status_word;
      default:    rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read in flight, data one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Two-stage synchronisers on all converter and sync pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_s1_q <= '0;
      port_a_s2_q <= '0;
      port_b_s1_q <= '0;
      port_b_s2_q <= '0;
      level_s1_q  <= 1'b0;
      level_s2_q  <= 1'b0;
      sync_s1_q   <= '0;
      sync_s2_q   <= '0;
    end else begin
      port_a_s1_q <= port_a;                                            // [R24]
      port_a_s2_q <= port_a_s1_q;
      port_b_s1_q <= port_b;
      port_b_s2_q <= port_b_s1_q;
      level_s1_q  <= level_indicator;
      level_s2_q  <= level_s1_q;
      sync_s1_q   <= sync_pins;
      sync_s2_q   <= sync_s1_q;
    end
  end

  // Port select moves samples, exponent and qualifier as one
  assign port_sel  = channel_front_control_q[CTRL_PORT_SEL] ? port_b_s2_q
                                                            : port_a_s2_q;  // [R11]
  assign qual_mode = cfr_qual_mode_t'(channel_front_control_q[CTRL_QUAL_LO +: 2]);

  // Qualifier decides latching and oscillator advance
  cfr_qualifier u_qualifier (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .mode       (qual_mode),
    .port_in    (port_sel),
    .sample_q   (q_sample),
    .exponent_q (q_exponent),
    .load_q     (q_load),
    .advance_q  (q_advance)
  );

  // Sync pin pick and hop detection
  assign sync_sel = sync_s2_q[channel_front_control_q[CTRL_SYNC_LO +: 2]];  // [R12]
  assign hop      = sync_sel && !sync_sel_prev_q;

  // Phase accumulator with hop handling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_sel_prev_q <= 1'b0;
      freq_active_q   <= RST_FREQ;
      phase_acc_q     <= '0;
    end else begin
      sync_sel_prev_q <= sync_sel;
      if (hop) begin
        freq_active_q <= freq_shadow_q;
        if (channel_front_control_q[CTRL_CLR_HOP]) begin
          phase_acc_q <= '0;                                            // [R2]
        end
      end else if (q_advance) begin
        phase_acc_q <= phase_acc_q + freq_active_q;       // [R3] [R5] [R6] [R9]
      end
    end
  end

  // Output phase with offset, and amplitude dither bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q           <= RST_LFSR;
      osc_phase_q      <= '0;
      osc_amp_dither_q <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      osc_phase_q      <= phase_acc_q[FREQ_W-1 -: PHASE_W] + phase_offset_q;  // [R2]
      osc_amp_dither_q <= channel_front_control_q[CTRL_AMP_DITHER] && lfsr_q[0];  // [R1]
    end
  end

  // Shift amount from exponent and selected scale field
  always_comb begin
    scale_pick = level_s2_q
               ? resampler_scale_control_q[SCALE_LOUD_LO +: SCALE_W]
               : resampler_scale_control_q[SCALE_QUIET_LO +: SCALE_W];  // [R16] [R17]
    exp_eff = resampler_scale_control_q[SCALE_INV]
            ? EXP_INV_BASE - {2'b00, q_exponent}                        // [R22]
            : {2'b00, q_exponent};
    if (resampler_scale_control_q[SCALE_WEIGHT]) begin
      exp_eff = exp_eff << 1;                                           // [R23]
    end
    shift_amt = exp_eff + scale_pick;                                   // [R18]
  end

  // Single scaling point ahead of the resampler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scaled_q      <= '0;
      scaled_load_q <= 1'b0;
    end else begin
      scaled_q      <= signed'(q_sample) >>> shift_amt;                 // [R19]
      scaled_load_q <= q_load;                                          // [R10]
    end
  end

  // Resampling comb
  cfr_resampler #(
    .ACC_W (ACC_W),
    .OUT_W (OUT_W)
  ) u_resampler (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sample      (scaled_q),
    .load        (scaled_load_q),
    .decim_m1    (decim_m1_q),
    .interp_m1   (interp_m1_q),
    .legal       (rate_legal),
    .out_data_q  (resampled_data),
    .out_valid_q (resampled_valid)
  );

endmodule

// ---- hdl/cfr_qualifier.sv ----
// Input qualifier: decides when a sample is latched and the oscillator advances
`timescale 1ns/1ns
module cfr_qualifier
  import cfr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire cfr_qual_mode_t    mode,
  input  wire cfr_port_t         port_in,
  output logic [DATA_W-1:0]      sample_q,
  output logic [EXP_W-1:0]       exponent_q,
  output logic                   load_q,
  output logic                   advance_q
);

  logic qual_prev_q;
  logic take;
  logic adv;

  // Latch and advance decisions per mode
  always_comb begin
    take = 1'b0;
    adv  = 1'b0;
    unique case (mode)
      QUAL_BLANK: begin
        take = 1'b1;                                  // [R4]
        adv  = 1'b1;                                  // [R5]
      end
      QUAL_HIGH: begin
        take = port_in.qualifier;                     // [R6]
        adv  = port_in.qualifier;                     // [R6]
      end
      QUAL_RISE: begin
        take = port_in.qualifier && !qual_prev_q;     // [R7]
        adv  = take;                                  // [R9]
      end
      QUAL_FALL: begin
        take = !port_in.qualifier && qual_prev_q;     // [R8]
        adv  = take;                                  // [R9]
      end
    endcase
  end

  // Sample capture, zero substitution while blanked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qual_prev_q <= 1'b0;
      sample_q    <= '0;
      exponent_q  <= '0;
      load_q      <= 1'b0;
      advance_q   <= 1'b0;
    end else begin
      qual_prev_q <= port_in.qualifier;
      load_q      <= take;
      advance_q   <= adv;
      if (take) begin
        exponent_q <= port_in.exponent;
        if (mode == QUAL_BLANK && !port_in.qualifier) begin
          sample_q <= '0;                             // [R4]
        end else begin
          sample_q <= port_in.samples;
        end
      end
    end
  end

endmodule

// ---- hdl/cfr_resampler.sv ----
// Second order resampling integrator-comb, at most one input per clock (on load), no fast clock
`timescale 1ns/1ns
module cfr_resampler
  import cfr_pkg::*;
#(
  parameter int ACC_W = 40,
  parameter int OUT_W = 24
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic signed [DATA_W-1:0] sample,
  input  wire logic                   load,
  input  wire logic [DECIM_W-1:0]     decim_m1,
  input  wire logic [INTERP_W-1:0]    interp_m1,
  output logic                        legal,
  output logic signed [OUT_W-1:0]     out_data_q,
  output logic                        out_valid_q
);

  logic signed [ACC_W-1:0] i1_q, i2_q, d1_q, d2_q;
  logic        [DECIM_W:0] cnt_q;
  logic        [DECIM_W:0] m_val, l_val, k_val, cnt_sum, cnt_n;
  logic signed [ACC_W-1:0] i1_n, i2_hit, i2_n, comb_y;
  logic                    hit, bypass;

  // Zero-stuffed block: L virtual subsamples per input, first holds the sample
  always_comb begin
    m_val   = {1'b0, decim_m1} + 13'h0001;                       // [R21]
    l_val   = {4'h0, interp_m1} + 13'h0001;                      // [R21]
    legal   = l_val <= m_val;                                    // [R13]
    bypass  = (decim_m1 == '0) && (interp_m1 == '0);             // [R15]
    i1_n    = i1_q + ACC_W'(sample);                             // [R14]
    k_val   = m_val - 13'h0001 - cnt_q;
    hit     = k_val < l_val;
    i2_hit  = i2_q + ACC_W'(signed'({1'b0, k_val + 13'h0001}) * i1_n);
    i2_n    = i2_q + ACC_W'(signed'({1'b0, l_val}) * i1_n);
    cnt_sum = cnt_q + l_val;
    cnt_n   = (cnt_sum >= m_val) ? cnt_sum - m_val : cnt_sum;
    comb_y  = i2_hit - (d1_q <<< 1) + d2_q;                       // [R14]
  end

  // Integrators, output-rate comb and strobe; steps only on a loaded sample at a legal rate, bypass loads skipping the integrators and comb
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i1_q        <= '0;
      i2_q        <= '0;
      d1_q        <= '0;
      d2_q        <= '0;
      cnt_q       <= '0;
      out_data_q  <= '0;
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= 1'b0;                                       // [R25]
      if (load && bypass) begin
        out_data_q  <= OUT_W'(sample);                           // [R15]
        out_valid_q <= 1'b1;                                     // [R25]
      end else if (load && legal) begin                          // [R20]
        i1_q  <= i1_n;
        i2_q  <= i2_n;
        cnt_q <= cnt_n;
        if (hit) begin
          d1_q        <= i2_hit;
          d2_q        <= d1_q;
          out_data_q  <= comb_y[OUT_W-1:0];
          out_valid_q <= 1'b1;                                   // [R25]
        end
      end
    end
  end

endmodule

// ---- pkg/cfr_pkg.sv ----
// Constants, field layouts and carrier types for the channel front end resampler
package cfr_pkg;

  // Data path widths
  localparam int DATA_W   = 14;
  localparam int EXP_W    = 3;
  localparam int SCALE_W  = 5;
  localparam int DECIM_W  = 12;
  localparam int INTERP_W = 9;
  localparam int CTRL_W   = 9;
  localparam int SSEL_W   = 12;
  localparam int FREQ_W   = 32;
  localparam int PHASE_W  = 16;
  localparam int IDX_W    = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FREQ   = 8'h85;
  localparam logic [IDX_W-1:0] IDX_PHASE  = 8'h87;
  localparam logic [IDX_W-1:0] IDX_CTRL   = 8'h88;
  localparam logic [IDX_W-1:0] IDX_DECIM  = 8'h90;
  localparam logic [IDX_W-1:0] IDX_INTERP = 8'h91;
  localparam logic [IDX_W-1:0] IDX_SCALE  = 8'h92;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h93;

  // Front control field positions
  localparam int CTRL_AMP_DITHER = 2;
  localparam int CTRL_CLR_HOP    = 3;
  localparam int CTRL_QUAL_LO    = 4;
  localparam int CTRL_PORT_SEL   = 6;
  localparam int CTRL_SYNC_LO    = 7;

  // Scale control field positions
  localparam int SCALE_LOUD_LO  = 0;
  localparam int SCALE_QUIET_LO = 5;
  localparam int SCALE_WEIGHT   = 10;
  localparam int SCALE_INV      = 11;
  localparam logic [SCALE_W-1:0] EXP_INV_BASE = 5'h07;

  // Status field positions
  localparam int STAT_LEGAL    = 0;
  localparam int STAT_QUAL     = 1;
  localparam int STAT_PHASE_LO = 16;

  // Values after reset
  localparam logic [CTRL_W-1:0]   RST_CTRL   = 9'h000;
  localparam logic [SSEL_W-1:0]   RST_SCALE  = 12'h000;
  localparam logic [DECIM_W-1:0]  RST_DECIM  = 12'h000;
  localparam logic [INTERP_W-1:0] RST_INTERP = 9'h000;
  localparam logic [FREQ_W-1:0]   RST_FREQ   = 32'h0000_0000;
  localparam logic [PHASE_W-1:0]  RST_PHASE  = 16'h0000;
  localparam logic [15:0]         RST_LFSR   = 16'hace1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Input qualifier modes in field order 00, 01, 10, 11
  typedef enum logic [1:0] {
    QUAL_BLANK,
    QUAL_HIGH,
    QUAL_RISE,
    QUAL_FALL
  } cfr_qual_mode_t;

  // One wideband input port
  typedef struct packed {
    logic [DATA_W-1:0] samples;
    logic [EXP_W-1:0]  exponent;
    logic              qualifier;
  } cfr_port_t;

endpackage

// ---- tb/cfr_adc_model.sv ----
// Wideband converter model driving one input port
`timescale 1ns/1ns
module cfr_adc_model
  import cfr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic [DATA_W-1:0] smp,
  input  wire logic [EXP_W-1:0]  ex,
  input  wire logic              qual,
  output cfr_port_t              port_q
);
  // All pins change together just after each edge
  always @(posedge aclk) begin
    port_q <= '{samples: smp, exponent: ex, qualifier: qual};
  end
endmodule

// ---- tb/cfr_sva.sv ----
// Handshake and output stream checks for the front end
`timescale 1ns/1ns
module cfr_sva #(
  parameter int OUT_W = 24
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic signed [OUT_W-1:0] resampled_data,
  input wire logic              resampled_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write channels taken together, only when no response waits
  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready) else $error("aw and w split");
  aw_take_a: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
    else $error("write taken without request");
  b_after_a: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no write response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  b_idle_a: assert property (!s_axi_bvalid && !s_axi_awready |=> !s_axi_bvalid)
    else $error("spurious write response");
  // Read channel
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  r_after_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // Output sample stands between strobes
  out_hold_a: assert property (##1 !resampled_valid |-> $stable(resampled_data))
    else $error("output changed without strobe");
endmodule

bind cfr_front_end cfr_sva #(.OUT_W(OUT_W)) u_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .resampled_data, .resampled_valid);

// ---- tb/testbench.sv ----
// Self-checking bench for the channel front end
`timescale 1ns/1ns
module testbench;
  import cfr_pkg::*;
  typedef struct {logic [11:0] scale; logic lvl; logic [2:0] ex; int res;} cfr_row_t;
  logic aclk = 0, aresetn = 0, level_indicator = 0, osc_amp_dither_q, resampled_valid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'hf, sync_pins = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic [13:0] a_smp = 14'h1000, b_smp = 14'h0800;
  logic [2:0] a_ex = '0, b_ex = '0;
  logic a_q = 1, b_q = 1;
  logic [15:0] osc_phase_q, p0;
  logic signed [23:0] resampled_data;
  cfr_port_t port_a, port_b;
  int err_count = 0, checks = 0, vcnt = 0, dcnt = 0, v0;
  cfr_row_t rows [5] = '{'{12'h061, 1, 2, 512}, '{12'h061, 0, 2, 128}, '{12'h861, 1, 2, 64},
                         '{12'h461, 1, 2, 128}, '{12'h01f, 1, 1, 4096}};

  cfr_front_end dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_a, .port_b, .level_indicator, .sync_pins,
    .osc_phase_q, .osc_amp_dither_q, .resampled_data, .resampled_valid);
  cfr_adc_model adc_a (.aclk, .smp(a_smp), .ex(a_ex), .qual(a_q), .port_q(port_a));
  cfr_adc_model adc_b (.aclk, .smp(b_smp), .ex(b_ex), .qual(b_q), .port_q(port_b));

  // Clock and strobe counters
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) begin
    if (resampled_valid === 1'b1) vcnt++;
    if (osc_amp_dither_q === 1'b1) dcnt++;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait on one design flag, sampled mid-cycle
  task automatic wt(input int k);
    for (int n = 0; n < 200; n++) begin
      @(negedge aclk);
      if ((k == 0 ? s_axi_awready : k == 1 ? s_axi_bvalid : k == 2 ? s_axi_arready :
           k == 3 ? s_axi_rvalid : resampled_valid) === 1'b1) return;
    end
    err_count++;
    wrap_up();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    wt(0);
    @(posedge aclk);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    wt(1);
    rd_r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    wt(2);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    wt(3);
    rd_v = s_axi_rdata;
    rd_r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask

  // Qualifier mode: one pulse, then phase advance and output count
  task automatic qm(input logic [8:0] c, input logic idle, input int adv, input int nv);
    @(posedge aclk);
    a_q <= idle;
    wr(12'h220, {23'h0, c});
    repeat (8) @(posedge aclk);
    @(negedge aclk) p0 = osc_phase_q;
    v0 = vcnt;
    @(posedge aclk) a_q <= !idle;
    repeat (3) @(posedge aclk);
    a_q <= idle;
    repeat (10) @(posedge aclk);
    @(negedge aclk) chk("phase step", 32'(adv), 32'(osc_phase_q - p0));
    if (nv >= 0) chk("sample count", 32'(nv), 32'(vcnt - v0));
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    foreach (rows[i]) begin
      @(posedge aclk);
      level_indicator <= rows[i].lvl;
      a_ex <= rows[i].ex;
      wr(12'h248, {20'h0, rows[i].scale});
      repeat (8) @(posedge aclk);
      wt(4);
      chk("scaled", 32'(rows[i].res), 32'(resampled_data));
    end
    $display("scaling rows done");
    @(posedge aclk) b_ex <= 3'd1;
    wr(12'h248, 32'h0);
    wr(12'h220, 32'h040);
    repeat (8) @(posedge aclk);
    wt(4);
    chk("port b sample", 32'd1024, 32'(resampled_data));
    $display("port select done");
    wr(12'h214, 32'h0001_0000);
    wr(12'h220, 32'h0);
    sync_pins <= 4'h1;
    repeat (4) @(posedge aclk);
    sync_pins <= 4'h0;
    qm(9'h000, 0, 14, -1);
    chk("blanked data", 32'h0, 32'(resampled_data));
    qm(9'h010, 0, 3, 3);
    qm(9'h020, 0, 1, 1);
    qm(9'h030, 1, 1, 1);
    chk("dither off", 32'h0, 32'(dcnt));
    $display("qualifier modes done");
    wr(12'h220, 32'h10c);
    @(posedge aclk) sync_pins <= 4'h4;
    repeat (10) @(posedge aclk);
    @(negedge aclk) chk("hop clear", 32'd6, 32'(osc_phase_q));
    wr(12'h240, 32'h1);
    repeat (8) @(posedge aclk);
    @(negedge aclk) v0 = vcnt;
    repeat (20) @(posedge aclk);
    @(negedge aclk) chk("decimate by two", 32'd10, 32'(vcnt - v0));
    chk("dither on", 32'h1, 32'(dcnt > 0));
    rd(12'h24c);
    chk("legal flag", 32'h1, 32'(rd_v[0]));
    wr(12'h244, 32'h2);
    rd(12'h24c);
    chk("illegal flag", 32'h0, 32'(rd_v[0]));
    @(negedge aclk) v0 = vcnt;
    repeat (20) @(posedge aclk);
    @(negedge aclk) chk("illegal output", 32'h0, 32'(vcnt - v0));
    $display("resampler done");
    wr(12'h244, 32'hffff_ffff);
    rd(12'h244);
    chk("interp width", 32'h1ff, rd_v);
    wr(12'h240, 32'hffff_ffff);
    rd(12'h240);
    chk("decim width", 32'hfff, rd_v);
    rd(12'h300);
    chk("unmapped data", 32'h0, rd_v);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rd_r));
    wr(12'h300, 32'h5);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(rd_r));
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(12'h240);
    chk("decim reset", 32'(RST_DECIM), rd_v);
    rd(12'h220);
    chk("control reset", 32'(RST_CTRL), rd_v);
    $display("registers and reset done");
    wrap_up();
  end
endmodule
